/* rtl/id_bank_pkg.sv */
// identification bank: offsets, field layout, reset values, link states and decode helpers
// assumes a single 40 MHz device clock shared by every user of this package
package id_bank_pkg;

  // ****************************************
  // register indices on the serial link
  // ****************************************
  localparam logic [15:0] IDX_MODEL_CODE = 16'h0000;  // device_model_code
  localparam logic [15:0] IDX_MODEL_MAJOR = 16'h0001; // model_major_revision
  localparam logic [15:0] IDX_MODEL_MINOR = 16'h0002; // model_minor_revision
  localparam logic [15:0] IDX_MODULE_MAJOR = 16'h0003; // module_major_revision
  localparam logic [15:0] IDX_MODULE_MINOR = 16'h0004; // module_minor_revision
  localparam logic [15:0] IDX_DATE = 16'h0006;         // manufacture_year_month

  // ****************************************
  // field layout and write masks
  // ****************************************
  localparam int DATE_YEAR_MSB = 7;   // last year digit
  localparam int DATE_YEAR_LSB = 4;
  localparam int DATE_MONTH_MSB = 3;  // month number
  localparam int DATE_MONTH_LSB = 0;
  localparam logic [7:0] MASK_FULL = 8'hFF; // whole byte writable
  localparam logic [7:0] MASK_REV = 8'h07;  // three-bit revision field
  localparam logic [7:0] MASK_NONE = 8'h00; // unmapped or reserved

  // ****************************************
  // reset values before the boot load
  // ****************************************
  localparam logic [7:0] RST_MODEL_CODE = 8'h5A;   // arbitrary model code
  localparam logic [7:0] RST_MODEL_MAJOR = 8'h06;  // arbitrary revision
  localparam logic [7:0] RST_MODEL_MINOR = 8'h05;  // arbitrary revision
  localparam logic [7:0] RST_MODULE_MAJOR = 8'h00; // replaced at boot
  localparam logic [7:0] RST_MODULE_MINOR = 8'h00; // replaced at boot
  localparam logic [7:0] RST_DATE = 8'h00;         // replaced at boot
  localparam logic [7:0] RST_UNUSED = 8'h00;       // unmapped slots
  localparam logic [7:0][7:0] STORE_RST = {RST_UNUSED, RST_DATE, RST_UNUSED,
    RST_MODULE_MINOR, RST_MODULE_MAJOR, RST_MODEL_MINOR, RST_MODEL_MAJOR, RST_MODEL_CODE};

  // ****************************************
  // serial link and boot load constants
  // ****************************************
  localparam logic [6:0] DEV_ADDR = 7'h2A;   // arbitrary slave address
  localparam logic [3:0] LINK_BITS = 4'h8;   // bits per byte
  localparam logic [1:0] BOOT_LAST = 2'h3;   // last entry of the load list
  localparam logic [3:0][2:0] BOOT_LIST = {3'h6, 3'h4, 3'h3, 3'h2}; // slots loaded at boot

  // link protocol states
  typedef enum logic [2:0] {
    LK_IDLE, LK_ADDR, LK_ACK, LK_IDXH, LK_IDXL, LK_WR, LK_RD, LK_RACK
  } link_state_t;

  // writable bits of a register, zero for unmapped indices
  function automatic logic [7:0] wr_mask(input logic [15:0] idx);
    case (idx)
      IDX_MODEL_CODE, IDX_DATE: wr_mask = MASK_FULL;
      IDX_MODEL_MAJOR, IDX_MODEL_MINOR, IDX_MODULE_MAJOR, IDX_MODULE_MINOR: wr_mask = MASK_REV;
      default: wr_mask = MASK_NONE;
    endcase
  endfunction

  // true when the index names a register of the bank
  function automatic logic is_mapped(input logic [15:0] idx);
    is_mapped = (wr_mask(idx) != MASK_NONE);
  endfunction

endpackage

/* rtl/id_store.sv */
// identification store: eight byte slots with one write port and a registered read port
// assumes writes arrive already masked and that the clock enable freezes everything
`timescale 1ns/1ps
`default_nettype none
module id_store (
  // clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // write port
  input wire logic we_i,
  input wire logic [2:0] waddr_i,
  input wire logic [7:0] wdata_i,
  // read port
  input wire logic [2:0] raddr_i,
  output logic [7:0] rdata_o
);
  import id_bank_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0][7:0] mem; // byte slots
    logic [7:0] rdata;    // registered read data
  } store_t;

  store_t q; // current state
  store_t d; // next state

  // next state: write slot, sample read slot
  always_comb begin
    d = q;
    if (we_i) begin
      d.mem[waddr_i] = wdata_i;
    end
    d.rdata = q.mem[raddr_i];
  end

  // registers, held while the enable is low
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '{mem: STORE_RST, rdata: RST_UNUSED};
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_code_write:
    assert property (we_i && ce_i && waddr_i == IDX_MODEL_CODE[2:0]
      |=> q.mem[IDX_MODEL_CODE[2:0]] == $past(wdata_i))
    else $error("model code not stored");
  a_major_resv_zero:
    assert property ((q.mem[IDX_MODEL_MAJOR[2:0]] & ~MASK_REV) == MASK_NONE)
    else $error("model major reserved bits set");
  a_minor_resv_zero:
    assert property ((q.mem[IDX_MODEL_MINOR[2:0]] & ~MASK_REV) == MASK_NONE)
    else $error("model minor reserved bits set");
  a_module_major_write:
    assert property (we_i && ce_i && waddr_i == IDX_MODULE_MAJOR[2:0]
      |=> q.mem[IDX_MODULE_MAJOR[2:0]] == $past(wdata_i))
    else $error("module major not stored");
  a_module_minor_zero:
    assert property ((q.mem[IDX_MODULE_MINOR[2:0]] & ~MASK_REV) == MASK_NONE)
    else $error("module minor reserved bits set");
  a_date_fields:
    assert property (we_i && ce_i && waddr_i == IDX_DATE[2:0]
      |=> q.mem[IDX_DATE[2:0]][DATE_YEAR_MSB:DATE_YEAR_LSB] ==
            $past(wdata_i[DATE_YEAR_MSB:DATE_YEAR_LSB]) &&
          q.mem[IDX_DATE[2:0]][DATE_MONTH_MSB:DATE_MONTH_LSB] ==
            $past(wdata_i[DATE_MONTH_MSB:DATE_MONTH_LSB]))
    else $error("date fields not stored");
endmodule
`default_nettype wire

/* rtl/id_bank.sv */
// identification register bank behind a two-wire serial register link
// assumes scl and sda come from pins and the store loader shares the device clock
// Function
// - model code byte at index 0x000
// - model major revision in bits 2:0
// - model minor revision in bits 2:0
// - module major revision records store version
// - module minor revision in bits 2:0
// - boot load replaces the defaults of slots 2, 3, 4 and 6 before host access
// - date byte: year digit high, month low
`timescale 1ns/1ps
`default_nettype none
module id_bank (
  // clock, reset and enable
  input wire logic SYS_CLK_I,
  input wire logic RST_B_I,
  input wire logic CE_I,
  // serial link pins
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_B_O,
  // nonvolatile store load port
  output logic STORE_RD_O,
  output logic [2:0] STORE_ADDR_O,
  input wire logic STORE_ACK_I,
  input wire logic [7:0] STORE_DATA_I,
  // status
  output logic BOOT_DONE_O
);
  import id_bank_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [2:0] scl_sync;  // [0] first stage, [2] previous value
    logic [2:0] sda_sync;
    link_state_t st;       // link state
    link_state_t nxt;      // state after the acknowledge bit
    logic [3:0] cnt;       // bit counter
    logic [7:0] sh;        // byte shifter
    logic [15:0] idx;      // register index, auto-incrementing
    logic sda_o;           // pin level when driven
    logic sda_oe_b;        // low while pulling sda low
    logic wr_req;          // store write pulse
    logic [2:0] wr_addr;
    logic [7:0] wr_data;
    logic boot_done;       // store load finished
    logic [1:0] boot_ptr;  // entry of the load list
    logic load_rd;         // load request pending
    logic [2:0] load_addr;
  } bank_t;

  localparam bank_t BANK_RST = '{scl_sync: 3'h7, sda_sync: 3'h7, st: LK_IDLE, nxt: LK_IDLE,
    cnt: 4'h0, sh: 8'h00, idx: 16'h0000, sda_o: 1'b0, sda_oe_b: 1'b1, wr_req: 1'b0,
    wr_addr: 3'h0, wr_data: 8'h00, boot_done: 1'b0, boot_ptr: 2'h0, load_rd: 1'b0,
    load_addr: 3'h0};

  bank_t q; // current state
  bank_t d; // next state
  logic [7:0] store_rdata; // byte at the current index
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] rd_byte;     // read answer, zero for unmapped indices

  // ****************************************
  // byte store
  // ****************************************
  id_store u_store (
    .clk_i(SYS_CLK_I),
    .rst_b_i(RST_B_I),
    .ce_i(CE_I),
    .we_i(q.wr_req),
    .waddr_i(q.wr_addr),
    .wdata_i(q.wr_data),
    .raddr_i(q.idx[2:0]),
    .rdata_o(store_rdata)
  );

  // ****************************************
  // pin events from the synchronised copies
  // ****************************************
  always_comb begin
    scl_rise = q.scl_sync[1] && !q.scl_sync[2];
    scl_fall = !q.scl_sync[1] && q.scl_sync[2];
    start_seen = q.scl_sync[1] && q.scl_sync[2] && q.sda_sync[2] && !q.sda_sync[1];
    stop_seen = q.scl_sync[1] && q.scl_sync[2] && !q.sda_sync[2] && q.sda_sync[1];
    rd_byte = is_mapped(q.idx) ? store_rdata : MASK_NONE;
  end

  // next state: synchronisers, boot load, link protocol
  always_comb begin
    d = q;
    d.scl_sync = {q.scl_sync[1:0], SCL_I};
    d.sda_sync = {q.sda_sync[1:0], SDA_I};
    d.wr_req = 1'b0;
    // boot load: one request per list entry, written masked on acknowledge
    if (!q.boot_done) begin
      if (!q.load_rd) begin
        d.load_rd = 1'b1;
        d.load_addr = BOOT_LIST[q.boot_ptr];
      end else if (STORE_ACK_I) begin
        d.load_rd = 1'b0;
        d.wr_req = 1'b1;
        d.wr_addr = q.load_addr;
        d.wr_data = STORE_DATA_I & wr_mask({13'h0000, q.load_addr});
        if (q.boot_ptr == BOOT_LAST) begin
          d.boot_done = 1'b1;
        end else begin
          d.boot_ptr = q.boot_ptr + 2'h1;
        end
      end
    end
    // link: stop and start override any byte in flight
    if (stop_seen) begin
      d.st = LK_IDLE;
      d.sda_oe_b = 1'b1;
    end else if (start_seen) begin
      d.st = LK_ADDR;
      d.cnt = 4'h0;
      d.sda_oe_b = 1'b1;
    end else begin
      case (q.st)
        LK_IDLE: begin
          d.sda_oe_b = 1'b1;
        end
        // receiving states: shift on rise, act after the eighth bit
        LK_ADDR, LK_IDXH, LK_IDXL, LK_WR: begin
          if (scl_rise) begin
            d.sh = {q.sh[6:0], q.sda_sync[1]};
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == LINK_BITS) begin
            d.cnt = 4'h0;
            d.st = LK_ACK;
            d.sda_oe_b = 1'b0;
            case (q.st)
              LK_ADDR: begin
                // no acknowledge until the boot load is over
                if (q.sh[7:1] == DEV_ADDR && q.boot_done) begin
                  d.nxt = q.sh[0] ? LK_RD : LK_IDXH;
                end else begin
                  d.st = LK_IDLE;
                  d.sda_oe_b = 1'b1;
                end
              end
              LK_IDXH: begin
                d.idx[15:8] = q.sh;
                d.nxt = LK_IDXL;
              end
              LK_IDXL: begin
                d.idx[7:0] = q.sh;
                d.nxt = LK_WR;
              end
              default: begin
                // data byte: store writable bits only, then step the index
                if (is_mapped(q.idx)) begin
                  d.wr_req = 1'b1;
                  d.wr_addr = q.idx[2:0];
                  d.wr_data = q.sh & wr_mask(q.idx);
                end
                d.idx = q.idx + 16'h0001;
                d.nxt = LK_WR;
              end
            endcase
          end
        end
        // acknowledge bit: release or start the read byte on the next fall
        LK_ACK: begin
          if (scl_fall) begin
            if (q.nxt == LK_RD) begin
              d.sda_oe_b = rd_byte[7];
              d.sh = {rd_byte[6:0], 1'b0};
              d.cnt = 4'h1;
              d.st = LK_RD;
            end else begin
              d.sda_oe_b = 1'b1;
              d.st = q.nxt;
            end
          end
        end
        // read byte: one bit per fall, msb first
        LK_RD: begin
          if (scl_fall) begin
            if (q.cnt == LINK_BITS) begin
              d.sda_oe_b = 1'b1;
              d.cnt = 4'h0;
              d.st = LK_RACK;
            end else begin
              d.sda_oe_b = q.sh[7];
              d.sh = {q.sh[6:0], 1'b0};
              d.cnt = q.cnt + 4'h1;
            end
          end
        end
        // host acknowledge: continue with the next index or stop
        LK_RACK: begin
          if (scl_rise) begin
            if (q.sda_sync[1]) begin
              d.st = LK_IDLE;
            end else begin
              d.idx = q.idx + 16'h0001;
              d.nxt = LK_RD;
              d.st = LK_ACK;
            end
          end
        end
        default: begin
          d.st = LK_IDLE;
          d.sda_oe_b = 1'b1;
        end
      endcase
    end
  end

  // registers, held while the enable is low
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      q <= BANK_RST;
    end else if (CE_I) begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign SDA_O = q.sda_o;
  assign SDA_OE_B_O = q.sda_oe_b;
  assign STORE_RD_O = q.load_rd;
  assign STORE_ADDR_O = q.load_addr;
  assign BOOT_DONE_O = q.boot_done;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_B_I);

  a_boot_bus_quiet:
    assert property (!q.boot_done |-> q.sda_oe_b)
    else $error("link driven before boot load");
  a_boot_load_write:
    assert property (q.load_rd && STORE_ACK_I && CE_I && !q.boot_done
      |=> q.wr_req && q.wr_addr == $past(q.load_addr) && !q.load_rd)
    else $error("loaded byte not written");
  a_boot_done_after:
    assert property ($rose(q.boot_done) |-> $past(STORE_ACK_I) && $past(q.boot_ptr) == BOOT_LAST)
    else $error("boot finished early");
  a_write_masked:
    assert property (q.wr_req |-> (q.wr_data & ~wr_mask({13'h0000, q.wr_addr})) == MASK_NONE
      && is_mapped({13'h0000, q.wr_addr}))
    else $error("reserved bits written");

  c_boot_done: cover property ($rose(q.boot_done));
  c_host_write: cover property (q.boot_done && q.wr_req);
  c_host_read: cover property (q.st == LK_RACK ##1 q.st == LK_ACK);
  c_addr_nack: cover property (q.st == LK_ADDR ##1 q.st == LK_IDLE);
endmodule
`default_nettype wire

/* verif/id_host_model.sv */
// host side model: bit-level two-wire master for the identification bank
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/1ps
`default_nettype none
module id_host_model (
  // clock
  input wire logic clk_i,
  // link pins
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // idle link: both lines released high
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // one link phase of 8 device clocks, changes land just after an edge
  task automatic hold();
    repeat (8) @(posedge clk_i);
    #2;
  endtask
  // start or repeated start, leaves scl low
  task automatic start();
    sda_o = 1'b1;
    hold();
    scl_o = 1'b1;
    hold();
    sda_o = 1'b0;
    hold();
    scl_o = 1'b0;
    hold();
  endtask
  // stop condition, leaves the link idle
  task automatic stop();
    sda_o = 1'b0;
    hold();
    scl_o = 1'b1;
    hold();
    sda_o = 1'b1;
    hold();
  endtask
  // one bit: drive b while scl low, sample the line at the end of the high phase
  task automatic bit_io(input logic b, output logic s);
    sda_o = b;
    hold();
    scl_o = 1'b1;
    hold();
    s = sda_i;
    scl_o = 1'b0;
    hold();
  endtask
  // one byte msb first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
    output logic ack_rx);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_tx, ack_rx);
  endtask
endmodule
`default_nettype wire

/* verif/id_bank_test.sv */
// self-checking bench for the identification register bank
// assumes the host model is compiled first; store loads come from a local responder
`timescale 1ns/1ps
`default_nettype none
module id_bank_test;
  import id_bank_pkg::*;
  // one ordinary case: optional write, then the byte read back
  typedef struct packed {
    logic [15:0] idx;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } row_t;
  logic SYS_CLK_I = 1'b0;
  logic RST_B_I = 1'b0;
  logic CE_I = 1'b1;
  logic SCL_I;
  logic SDA_I;
  logic SDA_O;
  logic SDA_OE_B_O;
  logic STORE_RD_O;
  logic [2:0] STORE_ADDR_O;
  logic STORE_ACK_I = 1'b0;
  logic [7:0] STORE_DATA_I = 8'h00;
  logic BOOT_DONE_O;
  logic host_sda; // host side of the data line
  logic load_go = 1'b0; // lets the responder answer load requests
  int dly = 0; // wait states before each load answer
  int n_seen = 0;
  logic [2:0] seen [4]; // slots in the order they were requested
  int n_fail = 0;
  int checks = 0;
  logic [7:0] rb [2];
  logic [7:0] rx;
  logic ak;
  logic [7:0] store_image [8] = '{8'h00, 8'h00, 8'hF6, 8'hAD, 8'h0C, 8'h00, 8'h71, 8'h00};
  row_t rows [13] = '{
    '{IDX_MODEL_CODE, 1'b0, 8'h00, RST_MODEL_CODE},
    '{IDX_MODEL_MAJOR, 1'b0, 8'h00, RST_MODEL_MAJOR},
    '{IDX_MODEL_MINOR, 1'b0, 8'h00, 8'h06},
    '{IDX_MODULE_MAJOR, 1'b0, 8'h00, 8'h05},
    '{IDX_MODULE_MINOR, 1'b0, 8'h00, 8'h04},
    '{IDX_DATE, 1'b0, 8'h00, 8'h71},
    '{IDX_MODEL_CODE, 1'b1, 8'hA5, 8'hA5},
    '{IDX_MODEL_MAJOR, 1'b1, 8'hFF, 8'h07},
    '{IDX_MODEL_MINOR, 1'b1, 8'hF8, 8'h00},
    '{IDX_MODULE_MAJOR, 1'b1, 8'h0D, 8'h05},
    '{IDX_MODULE_MINOR, 1'b1, 8'h6B, 8'h03},
    '{IDX_DATE, 1'b1, 8'h9C, 8'h9C},
    '{16'h0005, 1'b1, 8'h33, 8'h00}};
  // ****************************************
  // clock, wire and partners
  // ****************************************
  always #12.5 SYS_CLK_I = ~SYS_CLK_I;
  // open-drain data line with pull-up
  assign SDA_I = host_sda & SDA_OE_B_O;
  id_bank dut_u (
    .SYS_CLK_I(SYS_CLK_I),
    .RST_B_I(RST_B_I),
    .CE_I(CE_I),
    .SCL_I(SCL_I),
    .SDA_I(SDA_I),
    .SDA_O(SDA_O),
    .SDA_OE_B_O(SDA_OE_B_O),
    .STORE_RD_O(STORE_RD_O),
    .STORE_ADDR_O(STORE_ADDR_O),
    .STORE_ACK_I(STORE_ACK_I),
    .STORE_DATA_I(STORE_DATA_I),
    .BOOT_DONE_O(BOOT_DONE_O)
  );
  id_host_model host_u (.clk_i(SYS_CLK_I), .sda_i(SDA_I), .scl_o(SCL_I), .sda_o(host_sda));
  // store responder: two wait states, one-cycle ack, data scrambled when not valid
  always @(posedge SYS_CLK_I) begin
    #2;
    if (STORE_ACK_I) begin
      STORE_ACK_I = 1'b0;
      STORE_DATA_I = ~STORE_DATA_I;
    end else if (STORE_RD_O && load_go) begin
      if (dly == 2) begin
        STORE_ACK_I = 1'b1;
        STORE_DATA_I = store_image[STORE_ADDR_O];
        seen[n_seen % 4] = STORE_ADDR_O;
        n_seen++;
        dly = 0;
      end else begin
        dly++;
      end
    end
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // bounded wait for the boot load, then the synchroniser margin
  task automatic wait_boot();
    int n;
    n = 0;
    while (BOOT_DONE_O !== 1'b1 && n < 400) begin
      @(posedge SYS_CLK_I);
      n++;
    end
    check("boot done", 16'h0001, {15'h0000, BOOT_DONE_O});
    if (BOOT_DONE_O !== 1'b1) begin
      wrap_up();
    end
    repeat (4) @(posedge SYS_CLK_I);
    #2;
  endtask
  // start, address with write, both index bytes
  task automatic set_idx(input logic [15:0] idx, output logic [2:0] a);
    logic [7:0] r;
    host_u.start();
    host_u.byte_io({DEV_ADDR, 1'b0}, 1'b1, r, a[2]);
    host_u.byte_io(idx[15:8], 1'b1, r, a[1]);
    host_u.byte_io(idx[7:0], 1'b1, r, a[0]);
  endtask
  task automatic wr_reg(input logic [15:0] idx, input logic [7:0] d);
    logic [2:0] a;
    logic [7:0] r;
    logic ad;
    set_idx(idx, a);
    host_u.byte_io(d, 1'b1, r, ad);
    host_u.stop();
    check("write ack", 16'h0000, {12'h000, a, ad});
  endtask
  // read n bytes from idx, host acks all but the last
  task automatic rd_reg(input logic [15:0] idx, input int n, output logic [7:0] d [2]);
    logic [2:0] a;
    logic ar;
    logic ah;
    set_idx(idx, a);
    host_u.start();
    host_u.byte_io({DEV_ADDR, 1'b1}, 1'b1, rx, ar);
    for (int i = 0; i < n; i++) begin
      host_u.byte_io(8'hFF, (i == n - 1), d[i], ah);
    end
    host_u.stop();
    check("read ack", 16'h0000, {12'h000, a, ar});
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge SYS_CLK_I);
    #2;
    check("in reset", 16'h0000, {12'h000, SDA_O, STORE_RD_O, BOOT_DONE_O, ~SDA_OE_B_O});
    RST_B_I = 1'b1;
    repeat (2) @(posedge SYS_CLK_I);
    #2;
    check("first load", 16'h000A, {12'h000, STORE_RD_O, STORE_ADDR_O});
    // host is refused while the load is held back
    host_u.start();
    host_u.byte_io({DEV_ADDR, 1'b0}, 1'b1, rx, ak);
    host_u.stop();
    check("nack in boot", 16'h0001, {15'h0000, ak});
    load_go = 1'b1;
    wait_boot();
    check("load order", {4'h0, 3'h2, 3'h3, 3'h4, 3'h6}, {4'h0, seen[0], seen[1], seen[2], seen[3]});
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr_reg(rows[i].idx, rows[i].wdata);
      end
      rd_reg(rows[i].idx, 1, rb);
      check($sformatf("index %h", rows[i].idx), {8'h00, rows[i].exp}, {8'h00, rb[0]});
    end
    // burst read walks from the module major to the module minor revision
    rd_reg(IDX_MODULE_MAJOR, 2, rb);
    check("burst", 16'h0503, {rb[0], rb[1]});
    // date fields read back apart: year digit high, month low
    rd_reg(IDX_DATE, 1, rb);
    check("year month", 16'h090C, {4'h0, rb[0][7:4], 4'h0, rb[0][3:0]});
    // reset in mid-run restores defaults and reloads the store
    load_go = 1'b0;
    RST_B_I = 1'b0;
    n_seen = 0;
    repeat (2) @(posedge SYS_CLK_I);
    #2;
    check("second reset", 16'h0000, {14'h0000, STORE_RD_O, BOOT_DONE_O});
    RST_B_I = 1'b1;
    load_go = 1'b1;
    wait_boot();
    rd_reg(IDX_MODEL_CODE, 2, rb);
    check("after reload", {RST_MODEL_CODE, RST_MODEL_MAJOR}, {rb[0], rb[1]});
    rd_reg(IDX_DATE, 1, rb);
    check("date reload", 16'h0071, {8'h00, rb[0]});
    wrap_up();
  end
endmodule
`default_nettype wire
